//--- pkg/ext_sfr_map.svh
// constants for the extension special-function-register block
// assumes inclusion by ext_sfr_pkg only; ext_sfr_block uses its macros; holds only definitions
// Summary of operation
// - chip-select mode drives four upper pins as active-low selects, exactly one low.
// - selected pin comes from high address bits 7:6, one per 16K window.
// - control bit 7 chooses addressing mode (0) or chip-select mode (1).
// - in addressing mode control bits 3:0 feed the four upper pins.
// - control bits 6:4 always read back as 111b.
// - control register resets to 70h.
// - control register at 0a2h, byte access only, no bit addressing.
// - extra port register at 0a6h, byte only; drives port, reads pin input.
// - extra port register resets to 0ffh.
// - interrupt control at 0c0h, bit-addressable 0c0h-0c7h, resets to 00h.
// - trigger bit set means falling edge, clear means low level.
// - edge mode sets pending flag on edge, clears it on service.
// - enable bits allow or block each extra interrupt.
// - priority bits place each extra interrupt high or low.
// - eight vectors 03h to 3bh, extra interrupts at 33h and 3bh.
// - within a level poll order follows the vector table, 0 first.
// - indirect data move drives paging high byte onto high address port.
// - paging high byte is byte access only, resets to 00h.
// - idle holds strobes high, power-down low; ports hold, data bus floats.
// - in idle or power-down upper pins give zero or decoded select.
// - addressing mode shows bits 3:0 only on table reads and data moves.
`ifndef EXT_SFR_MAP_SVH
`define EXT_SFR_MAP_SVH
`define ADDR_PAGING_HIGH_BYTE 8'ha1
`define ADDR_EXT_ADDR_CTRL    8'ha2
`define ADDR_EXTRA_PORT       8'ha6
`define ADDR_EXT_IRQ_CTRL     8'hc0
`define RST_PAGING_HIGH_BYTE  8'h00
`define RST_EXT_ADDR_CTRL     8'h70
`define RST_EXTRA_PORT        8'hff
`define RST_EXT_IRQ_CTRL      8'h00
`define CTRL_RESERVED_READ    3'h7
`define BIT_MODE              7
`define BIT_IT2               0
`define BIT_IE2               1
`define BIT_EX2               2
`define BIT_PX2               3
`define BIT_IT3               4
`define BIT_IE3               5
`define BIT_EX3               6
`define BIT_PX3               7
`define VEC_IRQ_TWO           8'h33
`define VEC_IRQ_THREE         8'h3b
`define SEQ_IRQ_TWO           3'h6
`define SEQ_IRQ_THREE         3'h7
`endif

//--- pkg/ext_sfr_pkg.sv
// types for the extension sfr block
// assumes the map header sits on the include path
package ext_sfr_pkg;
  `include "ext_sfr_map.svh"
  typedef enum logic [1:0] {
    pwr_run_type   = 2'b00,
    pwr_idle_type  = 2'b01,
    pwr_down_type  = 2'b10
  } power_mode_type;
  typedef enum logic [1:0] {
    cyc_fetch_type = 2'b00,
    cyc_table_type = 2'b01,
    cyc_movx_type  = 2'b10,
    cyc_page_type  = 2'b11
  } bus_cycle_type;
endpackage

//--- rtl/ext_sfr_block.sv
// extension sfr bank: address extension, chip selects, extra port, two extra interrupts
// assumes the core gives one-cycle sfr read/write strobes and a bus cycle type per cycle
`timescale 1ns/100ps
module ext_sfr_block
  import ext_sfr_pkg::*;
(
  // clock and reset
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst_n,
  // sfr bus from core
  input  wire logic [7:0]      i_sfr_addr,
  input  wire logic [7:0]      i_sfr_wdata,
  input  wire logic            i_sfr_wr,
  input  wire logic            i_sfr_rd,
  input  wire logic            i_bit_wr,
  input  wire logic [7:0]      i_bit_addr,
  input  wire logic            i_bit_val,
  output logic [7:0]           o_sfr_rdata,
  // core bus cycle and address
  input  wire bus_cycle_type   i_cycle,
  input  wire logic [15:0]     i_core_addr,
  input  wire logic [7:0]      i_core_wdata,
  input  wire logic            i_data_drive,
  input  wire logic            i_ale,
  input  wire logic            i_store_strobe_n,
  input  wire power_mode_type  i_power_mode,
  // external memory pins
  output logic [7:0]           o_low_address_port,
  output logic [7:0]           o_high_address_port,
  output logic [3:0]           o_upper_address_pins,
  output logic [7:0]           o_muxed_data_bus_out,
  output logic                 o_muxed_data_bus_oe_n,
  output logic                 o_ale,
  output logic                 o_program_store_strobe_n,
  // extra port
  input  wire logic [7:0]      i_extra_port_pins,
  output logic [7:0]           o_extra_port_data,
  // extra interrupts
  input  wire logic            i_ext_irq_two_n,
  input  wire logic            i_ext_irq_three_n,
  input  wire logic            i_svc_irq_two,
  input  wire logic            i_svc_irq_three,
  output logic                 o_irq_two_req,
  output logic                 o_irq_three_req,
  output logic                 o_irq_two_high,
  output logic                 o_irq_three_high,
  output logic [7:0]           o_irq_two_vector,
  output logic [7:0]           o_irq_three_vector,
  output logic [2:0]           o_irq_two_sequence,
  output logic [2:0]           o_irq_three_sequence
);
  logic [7:0] paging_high_byte_q;
  logic [7:0] ctrl_q;
  logic [7:0] extra_port_data_q;
  logic [7:0] irq_ctrl_q;
  logic [7:0] port_sync1_q;
  logic [7:0] port_sync2_q;
  logic [7:0] port_sync3_q;
  logic [7:0] port_in_q;
  logic       pend_two;
  logic       pend_three;

  // one-hot active-low select from two high address bits
  function automatic logic [3:0] decode_select(input logic [1:0] hi);
    decode_select = ~(4'h1 << hi);
  endfunction

  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] target);
    is_wr = i_sfr_wr && (a == target);
  endfunction

  wire bit_hit   = i_bit_wr && (i_bit_addr[7:3] == 5'(`ADDR_EXT_IRQ_CTRL >> 3));
  wire [2:0] bsel = i_bit_addr[2:0];

  // byte registers; bit writes only reach the interrupt control
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      paging_high_byte_q <= `RST_PAGING_HIGH_BYTE;
    end else if (is_wr(i_sfr_addr, `ADDR_PAGING_HIGH_BYTE)) begin
      paging_high_byte_q <= i_sfr_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `RST_EXT_ADDR_CTRL;
    end else if (is_wr(i_sfr_addr, `ADDR_EXT_ADDR_CTRL)) begin
      ctrl_q <= {i_sfr_wdata[7], `CTRL_RESERVED_READ, i_sfr_wdata[3:0]};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      extra_port_data_q <= `RST_EXTRA_PORT;
    end else if (is_wr(i_sfr_addr, `ADDR_EXTRA_PORT)) begin
      extra_port_data_q <= i_sfr_wdata;
    end
  end

  // software bits of the interrupt control; pending bits live in the edge units
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_ctrl_q <= `RST_EXT_IRQ_CTRL;
    end else if (is_wr(i_sfr_addr, `ADDR_EXT_IRQ_CTRL)) begin
      irq_ctrl_q <= i_sfr_wdata;
    end else if (bit_hit) begin
      irq_ctrl_q[bsel] <= i_bit_val;
    end
  end

  wire pend_wr_byte = is_wr(i_sfr_addr, `ADDR_EXT_IRQ_CTRL);
  wire two_sw_wr    = pend_wr_byte || (bit_hit && bsel == 3'(`BIT_IE2));
  wire three_sw_wr  = pend_wr_byte || (bit_hit && bsel == 3'(`BIT_IE3));
  wire two_sw_val   = pend_wr_byte ? i_sfr_wdata[`BIT_IE2] : i_bit_val;
  wire three_sw_val = pend_wr_byte ? i_sfr_wdata[`BIT_IE3] : i_bit_val;

  irq_edge_unit u_irq_two (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_pin_n     (i_ext_irq_two_n),
    .i_edge_mode (irq_ctrl_q[`BIT_IT2]),
    .i_service   (i_svc_irq_two),
    .i_sw_wr     (two_sw_wr),
    .i_sw_val    (two_sw_val),
    .o_pending   (pend_two)
  );

  irq_edge_unit u_irq_three (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_pin_n     (i_ext_irq_three_n),
    .i_edge_mode (irq_ctrl_q[`BIT_IT3]),
    .i_service   (i_svc_irq_three),
    .i_sw_wr     (three_sw_wr),
    .i_sw_val    (three_sw_val),
    .o_pending   (pend_three)
  );

  wire [7:0] irq_ctrl_view = {irq_ctrl_q[7:6], pend_three, irq_ctrl_q[4:2], pend_two, irq_ctrl_q[0]};

  // interrupt requests toward the core priority logic
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_two_req    <= 1'b0;
      o_irq_three_req  <= 1'b0;
      o_irq_two_high   <= 1'b0;
      o_irq_three_high <= 1'b0;
    end else begin
      o_irq_two_req    <= pend_two && irq_ctrl_q[`BIT_EX2];
      o_irq_three_req  <= pend_three && irq_ctrl_q[`BIT_EX3];
      o_irq_two_high   <= irq_ctrl_q[`BIT_PX2];
      o_irq_three_high <= irq_ctrl_q[`BIT_PX3];
    end
  end

  // constant vectors and poll positions, still registered for clean outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_two_vector     <= `VEC_IRQ_TWO;
      o_irq_three_vector   <= `VEC_IRQ_THREE;
      o_irq_two_sequence   <= `SEQ_IRQ_TWO;
      o_irq_three_sequence <= `SEQ_IRQ_THREE;
    end else begin
      o_irq_two_vector     <= `VEC_IRQ_TWO;
      o_irq_three_vector   <= `VEC_IRQ_THREE;
      o_irq_two_sequence   <= `SEQ_IRQ_TWO;
      o_irq_three_sequence <= `SEQ_IRQ_THREE;
    end
  end

  // extra port input, three stages with agreement filter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_sync1_q <= 8'hff;
      port_sync2_q <= 8'hff;
      port_sync3_q <= 8'hff;
      port_in_q    <= 8'hff;
    end else begin
      port_sync1_q <= i_extra_port_pins;
      port_sync2_q <= port_sync1_q;
      port_sync3_q <= port_sync2_q;
      port_in_q    <= (port_sync2_q & ~(port_sync2_q ^ port_sync3_q)) |
                      (port_in_q & (port_sync2_q ^ port_sync3_q));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_extra_port_data <= `RST_EXTRA_PORT;
    end else begin
      o_extra_port_data <= extra_port_data_q;
    end
  end

  // register read data; unmapped addresses read zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        `ADDR_PAGING_HIGH_BYTE: o_sfr_rdata <= paging_high_byte_q;
        `ADDR_EXT_ADDR_CTRL:    o_sfr_rdata <= {ctrl_q[7], `CTRL_RESERVED_READ, ctrl_q[3:0]};
        `ADDR_EXTRA_PORT:       o_sfr_rdata <= port_in_q;
        `ADDR_EXT_IRQ_CTRL:     o_sfr_rdata <= irq_ctrl_view;
        default:                o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  // address pins
  wire       low_power = (i_power_mode != pwr_run_type);
  wire       sel_mode  = ctrl_q[`BIT_MODE];
  wire [7:0] high_next = (i_cycle == cyc_page_type) ? paging_high_byte_q : i_core_addr[15:8];
  wire       ext_cycle = (i_cycle == cyc_table_type) || (i_cycle == cyc_movx_type) ||
                         (i_cycle == cyc_page_type);
  logic [3:0] upper_next;
  always_comb begin
    if (sel_mode) begin
      upper_next = decode_select(high_next[7:6]);
    end else if (ext_cycle && !low_power) begin
      upper_next = ctrl_q[3:0];
    end else begin
      upper_next = 4'h0;
    end
  end

  // in low power the address ports just keep their last value
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low_address_port   <= 8'h00;
      o_high_address_port  <= 8'h00;
      o_upper_address_pins <= 4'h0;
    end else begin
      if (!low_power) begin
        o_low_address_port  <= i_core_addr[7:0];
        o_high_address_port <= high_next;
      end
      o_upper_address_pins <= low_power ? (sel_mode ? decode_select(o_high_address_port[7:6]) : 4'h0)
                                        : upper_next;
    end
  end

  // strobes and data bus
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ale                    <= 1'b1;
      o_program_store_strobe_n <= 1'b1;
      o_muxed_data_bus_out     <= 8'h00;
      o_muxed_data_bus_oe_n    <= 1'b1;
    end else begin
      unique case (i_power_mode)
        pwr_idle_type: begin
          o_ale                    <= 1'b1;
          o_program_store_strobe_n <= 1'b1;
          o_muxed_data_bus_oe_n    <= 1'b1;
        end
        pwr_down_type: begin
          o_ale                    <= 1'b0;
          o_program_store_strobe_n <= 1'b0;
          o_muxed_data_bus_oe_n    <= 1'b1;
        end
        pwr_run_type: begin
          o_ale                    <= i_ale;
          o_program_store_strobe_n <= i_store_strobe_n;
          o_muxed_data_bus_oe_n    <= !i_data_drive;
          o_muxed_data_bus_out     <= i_core_wdata;
        end
        default: begin
          o_ale                    <= 1'b1;
          o_program_store_strobe_n <= 1'b1;
          o_muxed_data_bus_oe_n    <= 1'b1;
        end
      endcase
    end
  end
endmodule

//--- rtl/irq_edge_unit.sv
// one extra external interrupt: pin synchroniser, trigger detect, pending flag
// assumes the pin is asynchronous to i_sys_clk and that service pulses are one cycle
`timescale 1ns/100ps
module irq_edge_unit (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // pin and control
  input  wire logic i_pin_n,
  input  wire logic i_edge_mode,
  input  wire logic i_service,
  input  wire logic i_sw_wr,
  input  wire logic i_sw_val,
  // flag
  output logic      o_pending
);
  logic [2:0] sync_q;
  logic       level_q;
  logic       pend_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q <= 3'h7;
    end else begin
      sync_q <= {sync_q[1:0], i_pin_n};
    end
  end
  // a change counts once stages two and three agree
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_q <= 1'b1;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end
  wire fall = level_q && (sync_q[1] == sync_q[2]) && !sync_q[2];
  // detected edge wins over service or software clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
    end else if (!i_edge_mode) begin
      pend_q <= !level_q;
    end else if (fall) begin
      pend_q <= 1'b1;
    end else if (i_service) begin
      pend_q <= 1'b0;
    end else if (i_sw_wr) begin
      pend_q <= i_sw_val;
    end
  end
  assign o_pending = pend_q;
endmodule

//--- verification/ext_periph_model.sv
// far-side model: extra port pins and the two interrupt sources
// assumes the bench changes its controls off the clock edge
`timescale 1ns/100ps
module ext_periph_model (
  // from the block and the bench
  input  wire logic [7:0] i_port_drive,
  input  wire logic [7:0] i_ext_low,
  input  wire logic       i_two_low,
  input  wire logic       i_three_low,
  // to the block
  output logic [7:0]      o_port_pins,
  output logic            o_irq_two_n,
  output logic            o_irq_three_n
);
  // quasi-bidirectional pins: either side may pull low, pull-up otherwise
  assign o_port_pins   = i_port_drive & ~i_ext_low;
  // interrupt lines have pull-ups, so a released source reads high
  assign o_irq_two_n   = ~i_two_low;
  assign o_irq_three_n = ~i_three_low;
endmodule

//--- verification/ext_sfr_block_asserts.sv
// assertion checker for ext_sfr_block, bound to every instance
// assumes ext_sfr_pkg is compiled first; sees the top-level ports only
`timescale 1ns/100ps
module ext_sfr_block_asserts
  import ext_sfr_pkg::*;
(
  // clock, reset, sfr bus
  input wire logic           i_sys_clk,
  input wire logic           i_rst_n,
  input wire logic [7:0]     i_sfr_addr,
  input wire logic [7:0]     i_sfr_wdata,
  input wire logic           i_sfr_wr,
  input wire logic           i_sfr_rd,
  input wire logic [7:0]     o_sfr_rdata,
  // bus cycle and pins
  input wire bus_cycle_type  i_cycle,
  input wire logic [15:0]    i_core_addr,
  input wire power_mode_type i_power_mode,
  input wire logic [7:0]     o_low_address_port,
  input wire logic [7:0]     o_high_address_port,
  input wire logic [3:0]     o_upper_address_pins,
  input wire logic           o_muxed_data_bus_oe_n,
  input wire logic           o_ale,
  input wire logic           o_program_store_strobe_n,
  // interrupt constants
  input wire logic [7:0]     o_irq_two_vector,
  input wire logic [7:0]     o_irq_three_vector,
  input wire logic [2:0]     o_irq_two_sequence,
  input wire logic [2:0]     o_irq_three_sequence
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // shadows of the byte registers; bit writes cannot reach these addresses
  logic [7:0] ctrl_q;
  logic [7:0] page_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) ctrl_q <= 8'h70;
    else if (i_sfr_wr && i_sfr_addr == 8'ha2) ctrl_q <= i_sfr_wdata;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) page_q <= 8'h00;
    else if (i_sfr_wr && i_sfr_addr == 8'ha1) page_q <= i_sfr_wdata;
  end
  sequence ran_s;
    $past(i_power_mode) == pwr_run_type;
  endsequence
  sequence data_cyc_s;
    $past(i_cycle) != cyc_fetch_type && !$past(ctrl_q[7]);
  endsequence
  select_decode_a: assert property (
    $past(ctrl_q[7]) |-> o_upper_address_pins == ~(4'h1 << o_high_address_port[7:6]))
    else $error("chip select not decoded from high address bits");
  bank_pins_a: assert property (
    ran_s ##0 data_cyc_s |-> o_upper_address_pins == $past(ctrl_q[3:0]))
    else $error("upper pins miss bank bits on a data cycle");
  fetch_zero_a: assert property (
    !$past(ctrl_q[7]) && ($past(i_cycle) == cyc_fetch_type || $past(i_power_mode) != pwr_run_type)
    |-> o_upper_address_pins == 4'h0)
    else $error("upper pins not zero outside data cycles");
  idle_strobes_a: assert property ($past(i_power_mode) == pwr_idle_type |-> o_ale && o_program_store_strobe_n)
    else $error("strobes not high in idle");
  down_strobes_a: assert property ($past(i_power_mode) == pwr_down_type |-> !o_ale && !o_program_store_strobe_n)
    else $error("strobes not low in power down");
  hold_bus_a: assert property (
    $past(i_power_mode) != pwr_run_type
    |-> o_muxed_data_bus_oe_n && $stable(o_low_address_port) && $stable(o_high_address_port))
    else $error("bus not floating or address not held");
  page_port_a: assert property (
    ran_s |-> o_high_address_port == ($past(i_cycle) == cyc_page_type ? $past(page_q) : $past(i_core_addr[15:8])))
    else $error("high address port source wrong");
  ctrl_read_a: assert property (
    $past(i_sfr_rd) && $past(i_sfr_addr) == 8'ha2 |-> o_sfr_rdata == ($past(ctrl_q) | 8'h70))
    else $error("control register read value wrong");
  irq_const_a: assert property (
    {o_irq_two_vector, o_irq_three_vector, o_irq_two_sequence, o_irq_three_sequence} == {8'h33, 8'h3b, 3'h6, 3'h7})
    else $error("interrupt vector or polling order wrong");
endmodule
bind ext_sfr_block ext_sfr_block_asserts u_asserts (
  .i_sys_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .i_cycle, .i_core_addr,
  .i_power_mode, .o_low_address_port, .o_high_address_port, .o_upper_address_pins, .o_muxed_data_bus_oe_n, .o_ale,
  .o_program_store_strobe_n, .o_irq_two_vector, .o_irq_three_vector, .o_irq_two_sequence, .o_irq_three_sequence
);

//--- verification/ext_sfr_block_test.sv
// self-checking bench for ext_sfr_block with the far-side pin model
// assumes package, design, model and checker are compiled before it
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ext_sfr_block_test;
  import ext_sfr_pkg::*;
  logic           i_sys_clk, i_rst_n, i_sfr_wr, i_sfr_rd, i_bit_wr, i_bit_val, i_data_drive, i_ale, i_store_strobe_n;
  logic           i_svc_irq_two, i_svc_irq_three, i_ext_irq_two_n, i_ext_irq_three_n, two_low, three_low;
  logic           o_muxed_data_bus_oe_n, o_ale, o_program_store_strobe_n, o_irq_two_req, o_irq_three_req;
  logic           o_irq_two_high, o_irq_three_high;
  logic [2:0]     o_irq_two_sequence, o_irq_three_sequence;
  logic [3:0]     o_upper_address_pins;
  logic [7:0]     i_sfr_addr, i_sfr_wdata, i_bit_addr, i_core_wdata, o_sfr_rdata, o_low_address_port;
  logic [7:0]     o_high_address_port, o_muxed_data_bus_out, i_extra_port_pins, o_extra_port_data;
  logic [7:0]     o_irq_two_vector, o_irq_three_vector, ext_low, ctrl, page, d;
  logic [11:0]    held;
  logic [15:0]    i_core_addr;
  bus_cycle_type  i_cycle;
  power_mode_type i_power_mode;
  int             n_errors, n_compared, i;
  ext_sfr_block dut (
    .i_sys_clk, .i_rst_n, .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .i_bit_wr, .i_bit_addr, .i_bit_val,
    .o_sfr_rdata, .i_cycle, .i_core_addr, .i_core_wdata, .i_data_drive, .i_ale, .i_store_strobe_n, .i_power_mode,
    .o_low_address_port, .o_high_address_port, .o_upper_address_pins, .o_muxed_data_bus_out, .o_muxed_data_bus_oe_n,
    .o_ale, .o_program_store_strobe_n, .i_extra_port_pins, .o_extra_port_data, .i_ext_irq_two_n, .i_ext_irq_three_n,
    .i_svc_irq_two, .i_svc_irq_three, .o_irq_two_req, .o_irq_three_req, .o_irq_two_high, .o_irq_three_high,
    .o_irq_two_vector, .o_irq_three_vector, .o_irq_two_sequence, .o_irq_three_sequence
  );
  ext_periph_model far_side (
    .i_port_drive(o_extra_port_data), .i_ext_low(ext_low), .i_two_low(two_low), .i_three_low(three_low),
    .o_port_pins(i_extra_port_pins), .o_irq_two_n(i_ext_irq_two_n), .o_irq_three_n(i_ext_irq_three_n)
  );
  // k: 0 byte write, 1 read, 2 bit write; strobe stands for exactly one edge
  task automatic acc(input int k, input logic [7:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    {i_sfr_addr, i_bit_addr, i_sfr_wdata, i_bit_val} = {a, a, v, v[0]};
    {i_sfr_wr, i_sfr_rd, i_bit_wr} = 3'b100 >> k;
    @(negedge i_sys_clk);
    {i_sfr_wr, i_sfr_rd, i_bit_wr} = 3'b000;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    acc(1, a, 8'h00);
    `CHK("sfr read", e, o_sfr_rdata)
  endtask
  task automatic svc(input int w);
    @(negedge i_sys_clk);
    {i_svc_irq_three, i_svc_irq_two} = w ? 2'b10 : 2'b01;
    @(negedge i_sys_clk);
    {i_svc_irq_three, i_svc_irq_two} = 2'b00;
  endtask
  // pending needs the three-flop filter plus one edge (two in level mode), the request one more, well inside the 12-cycle bound
  task automatic wait_req(input int w, input logic e);
    for (int j = 0; j < 12; j++) begin
      @(negedge i_sys_clk);
      if ((w ? o_irq_three_req : o_irq_two_req) === e) return;
    end
    $display("[FAIL] irq request wait exp %h", e);
    n_errors++;
    final_report();
  endtask
  function automatic logic [11:0] exp_pins(logic [7:0] c, logic [7:0] hb, bus_cycle_type cy, logic [15:0] ad);
    logic [7:0] hi;
    hi = (cy == cyc_page_type) ? hb : ad[15:8];
    return {hi, c[7] ? ~(4'h1 << hi[7:6]) : (cy == cyc_fetch_type ? 4'h0 : c[3:0])};
  endfunction
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    {i_sfr_wr, i_sfr_rd, i_bit_wr, i_bit_val, i_data_drive, i_svc_irq_two, i_svc_irq_three, two_low, three_low} = '0;
    {i_sfr_addr, i_sfr_wdata, i_bit_addr, i_core_wdata, ext_low, i_core_addr} = '0;
    {i_ale, i_store_strobe_n} = 2'b11;
    i_cycle = cyc_fetch_type;
    i_power_mode = pwr_run_type;
    n_errors = 0;
    n_compared = 0;
    i_rst_n = 1'b0;
    d = 8'($urandom(99));
    repeat (10) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    `CHK("port data", 8'hff, o_extra_port_data)
    `CHK("irq consts", {8'h33, 8'h3b, 3'h6, 3'h7}, {o_irq_two_vector, o_irq_three_vector, o_irq_two_sequence, o_irq_three_sequence})
    rdc(8'ha1, 8'h00);
    rdc(8'ha2, 8'h70);
    rdc(8'hc0, 8'h00);
    rdc(8'ha3, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      ext_low = 8'($urandom);
      acc(0, 8'ha1, d);
      rdc(8'ha1, d);
      acc(0, 8'ha2, d);
      acc(2, 8'ha2, ~d);
      rdc(8'ha2, d | 8'h70);
      acc(0, 8'ha6, d);
      // the port output is one register behind the port register
      @(negedge i_sys_clk);
      `CHK("port data", d, o_extra_port_data)
      repeat (4) @(negedge i_sys_clk);
      rdc(8'ha6, d & ~ext_low);
    end
    for (i = 0; i < 8; i++) acc(2, 8'(8'hc0 + i), 8'h01);
    rdc(8'hc0, 8'hff);
    `CHK("irq high", 2'b11, {o_irq_three_high, o_irq_two_high})
    `CHK("irq req", 2'b11, {o_irq_three_req, o_irq_two_req})
    acc(2, 8'hc6, 8'h00);
    acc(0, 8'hc0, 8'h15);
    @(negedge i_sys_clk);
    `CHK("irq req", 2'b00, {o_irq_three_req, o_irq_two_req})
    `CHK("irq high", 2'b00, {o_irq_three_high, o_irq_two_high})
    two_low = 1'b1;
    wait_req(0, 1'b1);
    svc(0);
    wait_req(0, 1'b0);
    repeat (8) @(negedge i_sys_clk);
    `CHK("irq two req", 1'b0, o_irq_two_req)
    two_low = 1'b0;
    acc(0, 8'hc0, 8'h40);
    three_low = 1'b1;
    wait_req(1, 1'b1);
    svc(1);
    repeat (4) @(negedge i_sys_clk);
    `CHK("irq three req", 1'b1, o_irq_three_req)
    three_low = 1'b0;
    wait_req(1, 1'b0);
    for (i = 0; i < 40; i++) begin
      ctrl = i < 4 ? 8'h02 : i < 8 ? 8'h80 : 8'($urandom);
      page = 8'($urandom);
      acc(0, 8'ha2, ctrl);
      acc(0, 8'ha1, page);
      @(negedge i_sys_clk);
      i_cycle = bus_cycle_type'(i < 4 ? i : $urandom % 4);
      i_core_addr = i < 8 ? {i[1:0], 14'h3fff} : 16'($urandom);
      {i_ale, i_store_strobe_n, i_data_drive} = 3'($urandom);
      i_core_wdata = 8'($urandom);
      @(negedge i_sys_clk);
      `CHK("addr pins", exp_pins(ctrl, page, i_cycle, i_core_addr), {o_high_address_port, o_upper_address_pins})
      `CHK("run pins", {i_core_addr[7:0], i_ale, i_store_strobe_n, !i_data_drive, i_core_wdata}, {o_low_address_port, o_ale, o_program_store_strobe_n, o_muxed_data_bus_oe_n, o_muxed_data_bus_out})
    end
    held = exp_pins(ctrl, page, i_cycle, i_core_addr);
    for (i = 1; i < 3; i++) begin
      acc(0, 8'ha2, {i == 1, 7'h05});
      i_power_mode = power_mode_type'(i);
      i_core_addr = 16'($urandom);
      repeat (2) @(negedge i_sys_clk);
      `CHK("strobes", {2{i == 1}}, {o_ale, o_program_store_strobe_n})
      `CHK("held pins", {held[11:4], i == 1 ? ~(4'h1 << held[11:10]) : 4'h0}, {o_high_address_port, o_upper_address_pins})
    end
    i_power_mode = pwr_run_type;
    final_report();
  end
endmodule
